// ===== hw/fpaa_pkg.sv
/*
 * Shared constants and number formats of the float adder/accumulator.
 * Assumes a SystemVerilog compiler; imported by every design file.
 */
`default_nettype none

package fpaa_pkg;

    // ****************************************
    // Number formats
    // ****************************************
    typedef enum {
        half_narrow_exp_format,
        half_wide_exp_format,
        wide24_format
    } fpaa_format_t;

    localparam int unsigned FPAA_W_HALF   = 16;
    localparam int unsigned FPAA_W_WIDE   = 24;
    localparam int unsigned FPAA_E_NARROW = 5;
    localparam int unsigned FPAA_E_WIDE   = 8;

    // Guard bits kept below the fraction while aligning.
    localparam int unsigned FPAA_GUARD = 3;

    // ****************************************
    // Configuration limits and settings
    // ****************************************
    localparam int unsigned FPAA_MAX_STAGES = 5;
    localparam int unsigned FPAA_BUF_DEPTH  = 2;
    localparam logic        FPAA_OP_ADD     = 1'b0;
    localparam logic        FPAA_OP_SUB     = 1'b1;
    localparam logic        FPAA_TIE_HIGH   = 1'b1;

    // Word width of a format.
    function automatic int unsigned fpaa_width(fpaa_format_t f);
        return (f == wide24_format) ? FPAA_W_WIDE : FPAA_W_HALF;
    endfunction

    // Exponent width of a format.
    function automatic int unsigned fpaa_exp(fpaa_format_t f);
        return (f == half_narrow_exp_format) ? FPAA_E_NARROW
                                             : FPAA_E_WIDE;
    endfunction

endpackage

`default_nettype wire

// ===== hw/fpaa_fp_add.sv
/*
 * Combinational floating-point adder for sign, exponent, fraction words.
 * Assumes operands without infinities or NaNs; a subnormal larger operand gives zero, a subnormal smaller one adds its fraction without a hidden bit.
 */
`timescale 1ns/100ps
`default_nettype none

module fpaa_fp_add #(
    parameter int unsigned W = 16,
    parameter int unsigned E = 5
) (
    // Operands and operation
    input  wire logic [W-1:0] a_i,
    input  wire logic [W-1:0] b_i,
    input  wire logic         sub_i,
    // Result
    output logic      [W-1:0] sum_o
);
    import fpaa_pkg::*;

    localparam int unsigned M  = W - 1 - E;
    localparam int unsigned SW = M + 2 + FPAA_GUARD;
    localparam logic [E-1:0] EMAX = '1;

    // ****************************************
    // Order operands by magnitude
    // ****************************************
    wire logic         sgn_b   = b_i[W-1] ^ sub_i;
    wire logic         a_ge    = a_i[W-2:0] >= b_i[W-2:0];
    wire logic [W-1:0] big     = a_ge ? a_i : b_i;
    wire logic [W-1:0] sml     = a_ge ? b_i : a_i;
    wire logic         sgn_big = a_ge ? a_i[W-1] : sgn_b;
    wire logic         sgn_sml = a_ge ? sgn_b : a_i[W-1];
    wire logic [E-1:0] e_big   = big[W-2:M];
    wire logic [E-1:0] e_sml   = sml[W-2:M];
    wire logic [E-1:0] e_diff  = e_big - e_sml;

    // ****************************************
    // Align and add
    // ****************************************
    wire logic [SW-1:0] m_big = {1'b0, e_big != '0, big[M-1:0],
                                 {FPAA_GUARD{1'b0}}};
    wire logic [SW-1:0] m_sml = {1'b0, e_sml != '0, sml[M-1:0],
                                 {FPAA_GUARD{1'b0}}};
    wire logic [SW-1:0] m_sh  = (e_diff >= E'(SW)) ? '0 : m_sml >> e_diff;
    wire logic          eff_sub = sgn_big ^ sgn_sml;
    wire logic [SW-1:0] s_raw = eff_sub ? m_big - m_sh : m_big + m_sh;

    // ****************************************
    // Normalise
    // ****************************************
    int          lz;
    int          ex;
    logic [SW-1:0] norm;

    always_comb begin
        lz = SW;
        for (int i = 0; i < SW; i++) begin
            if (s_raw[i]) begin
                lz = SW - 1 - i;
            end
        end
        norm = s_raw << lz;
        ex   = int'(e_big) + 1 - lz;
    end

    // Underflow and zero flush to +0, overflow saturates to infinity.
    wire logic is_zero = (s_raw == '0) || (ex <= 0) || (e_big == '0);
    wire logic is_inf  = ex >= int'(EMAX);

    assign sum_o = is_zero ? '0
                 : is_inf  ? {sgn_big, EMAX, {M{1'b0}}}
                 : {sgn_big, E'(ex), norm[SW-2 -: M]};

endmodule // fpaa_fp_add

`default_nettype wire

// ===== hw/fpaa_buf2.sv
/*
 * Two-entry first-in first-out buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module fpaa_buf2 #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    // Filling side
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // Draining side
    output logic      [W-1:0] out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    import fpaa_pkg::*;

    logic [W-1:0] mem_q [FPAA_BUF_DEPTH];
    logic         wr_ptr_q;
    logic         rd_ptr_q;
    logic [1:0]   cnt_q;

    wire logic push = in_valid_i & in_ready_o;
    wire logic pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = cnt_q != 2'(FPAA_BUF_DEPTH);
    assign out_valid_o = cnt_q != 2'h0;
    assign out_data_o  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            cnt_q    <= cnt_q + 2'(push) - 2'(pop);
        end
    end

endmodule // fpaa_buf2

`default_nettype wire

// ===== hw/fpaa_top.sv
/*
 * Floating-point adder/subtractor with optional accumulation, optional
 * input registers, zero to five pipeline stages and an output buffer.
 * Assumes operands synchronous to clk_sys_i and a receiver that may
 * stall through result_ready_i.
 */
`timescale 1ns/100ps
`default_nettype none

module fpaa_top
    import fpaa_pkg::*;
#(
    parameter fpaa_pkg::fpaa_format_t FORMAT =
        fpaa_pkg::half_narrow_exp_format,
    parameter logic        SUBTRACT       = fpaa_pkg::FPAA_OP_ADD,
    parameter logic        ACCUM_EN       = 1'b0,
    parameter logic        IN_REG_EN      = 1'b0,
    parameter logic        HIDE_IN_CTRL   = 1'b0,
    parameter int unsigned PIPE_STAGES    = 0,
    parameter logic        HIDE_PIPE_CTRL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    // Operands
    input  wire logic [fpaa_pkg::fpaa_width(FORMAT)-1:0] opnd_a_i,
    input  wire logic [fpaa_pkg::fpaa_width(FORMAT)-1:0] opnd_b_i,
    input  wire logic in_valid_i,
    output logic      in_ready_o,
    input  wire logic restart_i,
    // Input register controls
    input  wire logic in_reg_a_ce_i,
    input  wire logic in_reg_b_ce_i,
    input  wire logic in_reg_rst_n_i,
    // Pipeline controls
    input  wire logic pipe_ce_i,
    input  wire logic pipe_rst_n_i,
    // Result
    output logic      [fpaa_pkg::fpaa_width(FORMAT)-1:0] result_o,
    output logic      result_valid_o,
    input  wire logic result_ready_i
);
    import fpaa_pkg::*;

    // ****************************************
    // Format
    // ****************************************
    // Word layout is sign, exponent, fraction from the top down.
    localparam int unsigned W = fpaa_width(FORMAT);
    localparam int unsigned E = fpaa_exp(FORMAT);
    // A stage count above the limit is clamped instead of wrapping.
    localparam int unsigned NS = (PIPE_STAGES > FPAA_MAX_STAGES)
                               ? FPAA_MAX_STAGES
                               : PIPE_STAGES;

    // ****************************************
    // Effective controls
    // ****************************************
    wire logic a_ce_eff;
    wire logic b_ce_eff;
    wire logic in_rst_n_eff;
    wire logic pipe_ce_eff;
    wire logic pipe_rst_n_eff;

    assign a_ce_eff     = HIDE_IN_CTRL ? FPAA_TIE_HIGH
                                       : in_reg_a_ce_i;
    assign b_ce_eff     = HIDE_IN_CTRL ? FPAA_TIE_HIGH
                                       : in_reg_b_ce_i;
    assign in_rst_n_eff = HIDE_IN_CTRL ? FPAA_TIE_HIGH
                                       : in_reg_rst_n_i;
    assign pipe_ce_eff    = HIDE_PIPE_CTRL ? FPAA_TIE_HIGH
                                           : pipe_ce_i;
    assign pipe_rst_n_eff = HIDE_PIPE_CTRL ? FPAA_TIE_HIGH
                                           : pipe_rst_n_i;

    // ****************************************
    // Handshake
    // ****************************************
    // The datapath moves only when the output buffer has room.
    // A refused pair waits at the inputs; nothing ahead of the output buffer moves either.
    wire logic buf_ready;
    wire logic adv;

    assign adv        = pipe_ce_eff & buf_ready;
    assign in_ready_o = adv;

    // ****************************************
    // Restart strobe
    // ****************************************
    // The restart strobe only counts when accumulating.
    wire logic restart_eff;

    assign restart_eff = ACCUM_EN & restart_i;

    // ****************************************
    // Input stage
    // ****************************************
    wire logic [W-1:0] stg_a;
    wire logic [W-1:0] stg_b;
    wire logic         stg_vld;
    wire logic         stg_load;

    generate
        if (IN_REG_EN) begin : g_in_reg
            logic [W-1:0] a_q;
            logic [W-1:0] b_q;
            logic         vld_q;
            logic         load_q;
            wire logic    in_clr;
            wire logic    a_load;
            wire logic    b_load;

            // The input-register reset wins over both operand enables.
            assign in_clr = srst_i | ~in_rst_n_eff;
            assign a_load = a_ce_eff & adv;
            assign b_load = b_ce_eff & adv;

            // Each operand keeps its own enable; control bits follow adv.
            always_ff @(posedge clk_sys_i) begin
                if (in_clr) begin
                    a_q <= '0;
                end else if (a_load) begin
                    a_q <= opnd_a_i;
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (in_clr) begin
                    b_q <= '0;
                end else if (b_load) begin
                    b_q <= opnd_b_i;
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (in_clr) begin
                    vld_q <= 1'b0;
                end else if (adv) begin
                    vld_q <= in_valid_i;
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (in_clr) begin
                    load_q <= 1'b0;
                end else if (adv) begin
                    load_q <= restart_eff;
                end
            end

            assign stg_a    = a_q;
            assign stg_b    = b_q;
            assign stg_vld  = vld_q;
            assign stg_load = load_q;
        end else begin : g_no_in_reg
            assign stg_a    = opnd_a_i;
            assign stg_b    = opnd_b_i;
            assign stg_vld  = in_valid_i;
            assign stg_load = restart_eff;
        end
    endgenerate

    // ****************************************
    // Operand adder
    // ****************************************
    wire logic [W-1:0] op_sum;

    fpaa_fp_add #(
        .W (W),
        .E (E)
    ) u_op_add (
        .a_i   (stg_a),
        .b_i   (stg_b),
        .sub_i (SUBTRACT),
        .sum_o (op_sum)
    );

    // ****************************************
    // Pipeline stages
    // ****************************************
    logic [W-1:0] pl_data [NS+1];
    logic         pl_vld  [NS+1];
    logic         pl_load [NS+1];

    assign pl_data[0] = op_sum;
    assign pl_vld[0]  = stg_vld;
    assign pl_load[0] = stg_load;

    // Pipeline reset wins over the pipeline enable, here and below.
    wire logic pipe_clr;

    assign pipe_clr = srst_i | ~pipe_rst_n_eff;

    generate
        for (genvar i = 0; i < NS; i++) begin : g_pipe
            // Data word of the stage.
            always_ff @(posedge clk_sys_i) begin
                if (pipe_clr) begin
                    pl_data[i+1] <= '0;
                end else if (adv) begin
                    pl_data[i+1] <= pl_data[i];
                end
            end

            // Valid and restart bits travel beside their word.
            always_ff @(posedge clk_sys_i) begin
                if (pipe_clr) begin
                    pl_vld[i+1]  <= 1'b0;
                    pl_load[i+1] <= 1'b0;
                end else if (adv) begin
                    pl_vld[i+1]  <= pl_vld[i];
                    pl_load[i+1] <= pl_load[i];
                end
            end
        end
    endgenerate

    wire logic [W-1:0] last_data;
    wire logic         last_vld;
    wire logic         last_load;

    assign last_data = pl_data[NS];
    assign last_vld  = pl_vld[NS];
    assign last_load = pl_load[NS];

    // ****************************************
    // Accumulator
    // ****************************************
    logic      [W-1:0] acc_q;
    wire logic [W-1:0] acc_sum;
    wire logic [W-1:0] out_word;
    wire logic         push;

    fpaa_fp_add #(
        .W (W),
        .E (E)
    ) u_acc_add (
        .a_i   (acc_q),
        .b_i   (last_data),
        .sub_i (FPAA_OP_ADD),
        .sum_o (acc_sum)
    );

    // Restart discards the old total; otherwise the new value is added.
    assign out_word = !ACCUM_EN  ? last_data
                    : last_load ? last_data
                    : acc_sum;

    assign push = last_vld & adv;

    // The total is updated only as its word enters the buffer.
    wire logic acc_load;

    assign acc_load = ACCUM_EN & push;

    always_ff @(posedge clk_sys_i) begin
        if (pipe_clr) begin
            acc_q <= '0;
        end else if (acc_load) begin
            acc_q <= out_word;
        end
    end

    // ****************************************
    // Output buffer
    // ****************************************
    // A stalled receiver backs up into the pipeline; no word is lost.
    fpaa_buf2 #(
        .W (W)
    ) u_out_buf (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .in_data_i   (out_word),
        .in_valid_i  (push),
        .in_ready_o  (buf_ready),
        .out_data_o  (result_o),
        .out_valid_o (result_valid_o),
        .out_ready_i (result_ready_i)
    );

endmodule // fpaa_top

`default_nettype wire

// ===== tb/fpaa_chk.sv
/*
 * Port-level assertions for the float adder/accumulator top.
 * Assumes two pipeline stages plus the input register stage.
 */
`timescale 1ns/100ps
`default_nettype none

module fpaa_chk #(
    parameter int unsigned W              = 16,
    parameter logic        HIDE_PIPE_CTRL = 1'b0
) (
    // Clock and reset
    input wire logic         clk_sys_i,
    input wire logic         srst_i,
    // Watched ports
    input wire logic         in_valid_i,
    input wire logic         in_ready_o,
    input wire logic         in_reg_rst_n_i,
    input wire logic         pipe_ce_i,
    input wire logic         pipe_rst_n_i,
    input wire logic [W-1:0] result_o,
    input wire logic         result_valid_o,
    input wire logic         result_ready_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // ****************************************
    // Assertions
    // ****************************************
    rst_clear_a: assert property (disable iff (1'b0)
        srst_i |=> !result_valid_o)
        else $error("valid after reset");
    ready_pipe_a: assert property (
        !HIDE_PIPE_CTRL && !pipe_ce_i |-> !in_ready_o)
        else $error("ready with pipe disabled");
    ready_empty_a: assert property (
        pipe_ce_i && !result_valid_o |-> in_ready_o)
        else $error("empty buffer refuses");
    hold_stall_a: assert property (
        result_valid_o && !result_ready_i
        |=> result_valid_o && $stable(result_o))
        else $error("result dropped in stall");
    // Three register stages lie before the output buffer.
    lat_exact_a: assert property (
        (in_valid_i && in_ready_o && !result_valid_o && result_ready_i)
        ##1 (pipe_ce_i && pipe_rst_n_i && result_ready_i)[*3]
        |=> result_valid_o)
        else $error("result late");
    ce_freeze_a: assert property (
        !pipe_ce_i && !result_valid_o |=> !result_valid_o)
        else $error("moved with pipe disabled");
    pipe_rst_a: assert property (
        (!pipe_rst_n_i && !result_valid_o)[*2] |=> !result_valid_o)
        else $error("result after pipe reset");
    inreg_rst_a: assert property (
        (!in_reg_rst_n_i && pipe_ce_i && !result_valid_o)[*4]
        |=> !result_valid_o)
        else $error("result after input reset");

endmodule // fpaa_chk

bind fpaa_top fpaa_chk #(
    .W(fpaa_pkg::fpaa_width(FORMAT)),
    .HIDE_PIPE_CTRL(HIDE_PIPE_CTRL)
) u_chk (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .in_reg_rst_n_i(in_reg_rst_n_i), .pipe_ce_i(pipe_ce_i),
    .pipe_rst_n_i(pipe_rst_n_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .result_ready_i(result_ready_i)
);

`default_nettype wire

// ===== tb/fpaa_sink.sv
/*
 * Result receiver model: accepts always, never, or every other cycle.
 * Assumes mode_i is set by the bench off the rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module fpaa_sink (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    // Control and handshake
    input  wire logic [1:0] mode_i,
    output logic            ready_o
);
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= (mode_i == 2'h0) | ((mode_i == 2'h2) & ~ready_o);
        end
    end
endmodule // fpaa_sink

`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench: subtract mode, accumulation, input registers and
 * two pipeline stages, half format with the narrow exponent.
 * Assumes the design package and the sink model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
    import fpaa_pkg::*;
    // Two pipeline stages plus the input register stage.
    localparam int unsigned LAT = 2 + 1;
    logic        clk_sys_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic [15:0] a = 16'h0, b = 16'h0;
    logic        iv = 1'b0, rs = 1'b0, ace = 1'b1, bce = 1'b1;
    logic        irn = 1'b1, pce = 1'b1, prn = 1'b1;
    logic [1:0]  mode = 2'h0;
    wire logic   in_ready_o, result_valid_o, rdy;
    wire logic [15:0] result_o;
    logic [15:0] q[$];
    int          n_mismatch = 0, total_checks = 0, cyc = 0, n;

    fpaa_top #(.FORMAT(half_narrow_exp_format), .SUBTRACT(FPAA_OP_SUB),
        .ACCUM_EN(1'b1), .IN_REG_EN(1'b1), .HIDE_IN_CTRL(1'b0),
        .PIPE_STAGES(2), .HIDE_PIPE_CTRL(1'b0)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .opnd_a_i(a),
        .opnd_b_i(b), .in_valid_i(iv), .in_ready_o(in_ready_o),
        .restart_i(rs), .in_reg_a_ce_i(ace), .in_reg_b_ce_i(bce),
        .in_reg_rst_n_i(irn), .pipe_ce_i(pce), .pipe_rst_n_i(prn),
        .result_o(result_o), .result_valid_o(result_valid_o),
        .result_ready_i(rdy));
    fpaa_sink u_sink (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .mode_i(mode), .ready_o(rdy));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (result_valid_o && rdy) q.push_back(result_o);
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic send(input logic [15:0] av, bv, input logic r);
        a = av;
        b = bv;
        rs = r;
        iv = 1'b1;
        while (in_ready_o !== 1'b1) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic idle(input int c);
        iv = 1'b0;
        repeat (c) @(negedge clk_sys_i);
    endtask
    task automatic pop(input logic [15:0] e);
        if (q.size() == 0) check("count", 16'h0, 16'h1);
        else check("result", q.pop_front(), e);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(negedge clk_sys_i);
        srst_i = 1'b0;
        check("valid", 16'(result_valid_o), 16'h0);
        check("ready", 16'(in_ready_o), 16'h1);
        send(16'h4200, 16'h3c00, 1'b1);
        n = 0;
        iv = 1'b0;
        while (result_valid_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("latency", 16'(n), 16'(LAT));
        idle(2);
        pop(16'h4000);
        send(16'h4200, 16'h3c00, 1'b1);
        send(16'h4000, 16'h3c00, 1'b0);
        send(16'h4400, 16'h3c00, 1'b0);
        send(16'h4400, 16'h4000, 1'b1);
        idle(8);
        pop(16'h4000);
        pop(16'h4200);
        pop(16'h4600);
        pop(16'h4000);
        mode = 2'h1;
        a = 16'h4000;
        b = 16'h3c00;
        rs = 1'b1;
        iv = 1'b1;
        n = 0;
        repeat (10) begin
            if (in_ready_o) n++;
            @(negedge clk_sys_i);
        end
        check("accepted", 16'(n), 16'h5);
        idle(0);
        check("refused", 16'(in_ready_o), 16'h0);
        mode = 2'h2;
        idle(30);
        check("drained", 16'(q.size()), 16'h5);
        repeat (5) pop(16'h3c00);
        mode = 2'h0;
        send(16'h4200, 16'h3c00, 1'b1);
        ace = 1'b0;
        send(16'h4400, 16'h3c00, 1'b1);
        ace = 1'b1;
        bce = 1'b0;
        send(16'h4400, 16'h4000, 1'b1);
        idle(1);
        irn = 1'b0;
        idle(4);
        irn = 1'b1;
        ace = 1'b0;
        send(16'h4400, 16'h4000, 1'b1);
        idle(8);
        ace = 1'b1;
        bce = 1'b1;
        pop(16'h4000);
        pop(16'h4000);
        pop(16'h4200);
        pop(16'h0000);
        send(16'h4200, 16'h3c00, 1'b1);
        iv = 1'b0;
        pce = 1'b0;
        idle(6);
        check("ready", 16'(in_ready_o), 16'h0);
        check("frozen", 16'(q.size()), 16'h0);
        pce = 1'b1;
        idle(8);
        pop(16'h4000);
        send(16'h4400, 16'h3c00, 1'b1);
        idle(8);
        pop(16'h4200);
        prn = 1'b0;
        idle(2);
        prn = 1'b1;
        send(16'h4000, 16'h3c00, 1'b0);
        idle(8);
        pop(16'h3c00);
        close_out();
    end
endmodule // tb

`default_nettype wire
